// [testbench/serial_partner.sv]
// Far-side serial device: mode 0 slave and asynchronous station
`timescale 1ns/100ps
`default_nettype none
module serial_partner (
   // Line levels
   input wire logic data_pin,
   input wire logic out_pin,
   output logic data_drv
);
   // Released line sits at the pull-up level
   initial data_drv = 1'h1;
   task automatic m0_take(output logic [7:0] b, output int per);
      time t0;
      for (int i = 0; i < 8; i++) begin
         @(posedge out_pin);
         b[i] = data_pin;
         if (i == 0) t0 = $time;
         if (i == 1) per = $time - t0;
      end
   endtask : m0_take
   task automatic m0_give(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(negedge out_pin);
         data_drv = b[i];
      end
      @(posedge out_pin);
      data_drv = 1'h1;
   endtask : m0_give
   // High data bit 0 is needed so the start bit length can be timed
   task automatic line_take(input int per, input int n, output logic [10:0] v, output int start);
      time t0;
      v = '0;
      @(negedge out_pin);
      t0 = $time;
      @(posedge out_pin);
      start = $time - t0;
      #(per / 2);
      for (int i = 1; i < n; i++) begin
         v[i] = out_pin;
         #(per);
      end
   endtask : line_take
   task automatic line_give(input int per, input int n, input logic [10:0] v);
      // Offset keeps line changes away from the design's clock edges
      #13;
      for (int i = 0; i < n; i++) begin
         data_drv = v[i];
         #(per);
      end
      data_drv = 1'h1;
   endtask : line_give
endmodule : serial_partner
`default_nettype wire

// [testbench/serial_port_assertions.sv]
// Concurrent checks on the ports of the serial port
`timescale 1ns/100ps
`default_nettype none
module serial_port_assertions (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Serial side
   input wire logic serial_out_pin,
   input wire serial_port_pkg::ctrl_t serial_control,
   input wire logic serial_irq
);
   import serial_port_pkg::*;
   logic prev_r;
   logic [3:0] hold_r;
   wire logic m0 = !serial_control.sm0 && !serial_control.sm1;
   // Length of the last level of the out pin, saturating so idle gaps stay out of the check
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 1'h1;
         hold_r <= 4'hf;
      end else begin
         prev_r <= serial_out_pin;
         hold_r <= (serial_out_pin != prev_r) ? 4'h1 : ((hold_r == 4'hf) ? hold_r : hold_r + 4'h1);
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid) else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_irq_flags: assert property (serial_irq == (serial_control.ti || serial_control.ri))
      else $error("irq differs from done flags");
   a_flags_sticky: assert property ($fell(serial_control.ti) || $fell(serial_control.ri)
      |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("done flag cleared without a write");
   a_m0_half_period: assert property (m0 && (serial_out_pin != prev_r) && (hold_r < 4'h7)
      |-> hold_r == (serial_control.sm2 ? 4'h2 : 4'h6)) else $error("shift clock half period wrong");
   a_start_bit_low: assert property ($fell(serial_out_pin) && !m0 |=> !serial_out_pin [*8])
      else $error("start bit too short");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_m0_clock: cover property ($fell(serial_out_pin) && m0);
   c_async_rx: cover property (serial_control.ri && !m0);
endmodule : serial_port_assertions
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench of the serial port
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_cfg.svh"
module testbench;
   import serial_port_pkg::*;
   localparam logic [11:0] A_PWR = {2'b00, `SP_IDX_PWR, 2'b00};
   localparam logic [11:0] A_CTRL = {2'b00, `SP_IDX_CTRL, 2'b00};
   localparam logic [11:0] A_DATA = {2'b00, `SP_IDX_DATA, 2'b00};
   localparam logic [7:0] CT [3] = '{8'h88, 8'h88, 8'h40};
   localparam logic [7:0] PW [3] = '{8'h00, 8'h80, 8'h80};
   localparam int PER [3] = '{3200, 1600, 1600};
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic t1_overflow = 1'h0;
   logic [11:0] s_axi_awaddr = '0;
   logic [11:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0;
   logic s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic serial_data_out, serial_data_oe, serial_out_pin, serial_irq;
   ctrl_t serial_control;
   wire logic drv;
   // Data pin: the design wins while it drives, else the partner or its pull-up
   wire logic serial_data_in = serial_data_oe ? serial_data_out : drv;
   int bad_count = 0;
   int n_compared = 0;
   logic [1:0] r;
   logic [31:0] d;
   logic [7:0] b;
   logic [10:0] v;
   int per, start;
   serial_port serial_port_i (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .t1_overflow, .serial_data_in, .serial_data_out,
      .serial_data_oe, .serial_out_pin, .serial_control, .serial_irq);
   serial_partner serial_partner_i (.data_pin(serial_data_in), .out_pin(serial_out_pin), .data_drv(drv));
   always #25 sys_clk = ~sys_clk;
   // One overflow pulse every second clock
   always @(posedge sys_clk) t1_overflow <= ~t1_overflow;
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] dat, output logic [1:0] resp);
      logic aw_left, w_left;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, dat};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      aw_left = 1'h1;
      w_left = 1'h1;
      while (aw_left || w_left) begin
         @(posedge sys_clk);
         if (aw_left && s_axi_awready === 1'h1) begin
            aw_left = 1'h0;
            s_axi_awvalid <= 1'h0;
         end
         if (w_left && s_axi_wready === 1'h1) begin
            w_left = 1'h0;
            s_axi_wvalid <= 1'h0;
         end
      end
      while (s_axi_bvalid !== 1'h1) @(posedge sys_clk);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] resp);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      while (s_axi_rvalid !== 1'h1) @(posedge sys_clk);
      dat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : rd
   task automatic rc(input string what, input logic [11:0] a, input logic [7:0] exp);
      rd(a, d, r);
      chk(what, {24'h0, exp}, d);
   endtask : rc
   task automatic finish_test();
      if (bad_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      #1000000;
      bad_count++;
      finish_test();
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'h1;
      rc("pwr reset", A_PWR, `SP_PWR_RST);
      rc("ctrl reset", A_CTRL, `SP_CTRL_RST);
      rc("data reset", A_DATA, `SP_DATA_RST);
      wr(A_PWR, 8'hff, r);
      rc("pwr storage", A_PWR, `SP_PWR_WMASK);
      wr(A_PWR, 8'h00, r);
      wr(12'h100, 8'h55, r);
      chk("unmapped write resp", `SP_RESP_SLVERR, r);
      rd(12'h100, d, r);
      chk("unmapped read resp", `SP_RESP_SLVERR, r);
      chk("unmapped read data", 32'h0, d);
      for (int i = 0; i < 2; i++) begin
         wr(A_CTRL, i ? 8'h20 : 8'h00, r);
         fork
            serial_partner_i.m0_take(b, per);
            wr(A_DATA, i ? 8'h5a : 8'ha5, r);
         join
         chk("m0 tx byte", i ? 8'h5a : 8'ha5, b);
         chk("m0 clock period", i ? 200 : 600, per);
         repeat (10) @(posedge sys_clk);
         rc("m0 tx flag", A_CTRL, i ? 8'h22 : 8'h02);
      end
      // Second byte follows the clear, disable, enable sequence
      for (int i = 0; i < 2; i++) begin
         wr(A_CTRL, 8'h20, r);
         fork
            serial_partner_i.m0_give(i ? 8'h93 : 8'h6c);
            wr(A_CTRL, 8'h30, r);
         join
         repeat (10) @(posedge sys_clk);
         rc("m0 rx byte", A_DATA, i ? 8'h93 : 8'h6c);
         rc("m0 rx flag", A_CTRL, 8'h31);
      end
      for (int k = 0; k < 3; k++) begin
         wr(A_PWR, PW[k], r);
         wr(A_CTRL, CT[k], r);
         fork
            serial_partner_i.line_take(PER[k], k < 2 ? 11 : 10, v, start);
            wr(A_DATA, 8'h35, r);
         join
         chk("async frame", k < 2 ? {2'b11, 8'h35, 1'b0} : {2'b01, 8'h35, 1'b0}, v);
         chk("async bit time", PER[k], start);
         rc("async tx flag", A_CTRL, CT[k] | 8'h02);
      end
      wr(A_CTRL, 8'hb0, r);
      serial_partner_i.line_give(1600, 11, {2'b11, 8'hc3, 1'b0});
      repeat (10) @(posedge sys_clk);
      rc("m2 rx data", A_DATA, 8'hc3);
      rc("m2 rx ctrl", A_CTRL, 8'hb5);
      chk("irq level", 1, serial_irq);
      wr(A_CTRL, 8'hb0, r);
      serial_partner_i.line_give(1600, 11, {2'b10, 8'h3c, 1'b0});
      repeat (10) @(posedge sys_clk);
      rc("m2 rx skipped data", A_DATA, 8'hc3);
      rc("m2 rx skipped ctrl", A_CTRL, 8'hb0);
      // Mode high bit is written before bit 7 turns into the error flag
      wr(A_CTRL, 8'h50, r);
      wr(A_PWR, 8'hc0, r);
      serial_partner_i.line_give(1600, 10, {1'b0, 8'h81, 1'b0});
      repeat (10) @(posedge sys_clk);
      rc("m1 rx data", A_DATA, 8'h81);
      rc("m1 frame error", A_CTRL, 8'hd1);
      serial_partner_i.line_give(1600, 10, {1'b1, 8'h7e, 1'b0});
      repeat (10) @(posedge sys_clk);
      rc("m1 rx held data", A_DATA, 8'h81);
      rc("m1 error kept", A_CTRL, 8'hd1);
      wr(A_CTRL, 8'h50, r);
      rc("m1 error cleared", A_CTRL, 8'h50);
      finish_test();
   end
endmodule : testbench
bind serial_port serial_port_assertions serial_port_assertions_i (.sys_clk, .rst_n, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .serial_out_pin, .serial_control,
   .serial_irq);
`default_nettype wire

// [verilog/serial_port.sv]
// Serial port, modes 0 to 3, with an AXI4-Lite register slave
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_cfg.svh"

module serial_port (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Baud source
   input wire logic t1_overflow,
   // Serial pins
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_oe,
   output logic serial_out_pin,
   // Status
   output serial_port_pkg::ctrl_t serial_control,
   output logic serial_irq
);
   import serial_port_pkg::*;

   function automatic logic [11:0] addr_of(input logic [7:0] idx);
      addr_of = {2'b00, idx, 2'b00};
   endfunction : addr_of

   ctrl_t ctrl_r;
   logic fe_r, ren_prev_r, aw_hold_r, w_hold_r, wstrb0_r, t1_half_r;
   logic [7:0] pwr_r, rx_buf_r, wbyte_r, rx_load;
   logic [11:0] awaddr_r;
   logic do_write, wr_ctrl, wr_data, wr_pwr, baud_double, fe_enable;
   logic [1:0] mode;
   logic ti_set, ri_set, fe_set, rb8_val, ovs_tick;
   logic [6:0] presc_r;

   assign mode = {ctrl_r.sm0, ctrl_r.sm1};
   assign baud_double = pwr_r[`SP_PWR_DOUBLE];
   assign fe_enable = pwr_r[`SP_PWR_FEEN];
   assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
   assign wr_ctrl = do_write && wstrb0_r && (awaddr_r == addr_of(`SP_IDX_CTRL));
   assign wr_data = do_write && wstrb0_r && (awaddr_r == addr_of(`SP_IDX_DATA));
   assign wr_pwr = do_write && wstrb0_r && (awaddr_r == addr_of(`SP_IDX_PWR));

   // Write channel: address and data taken in either order
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 12'h000;
         wbyte_r <= 8'h00;
         wstrb0_r <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SP_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wbyte_r <= s_axi_wdata[7:0];
            wstrb0_r <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awaddr_r == addr_of(`SP_IDX_CTRL) || awaddr_r == addr_of(`SP_IDX_DATA) ||
                awaddr_r == addr_of(`SP_IDX_PWR)) begin
               s_axi_bresp <= `SP_RESP_OKAY;
            end else begin
               s_axi_bresp <= `SP_RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Read channel
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SP_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `SP_RESP_OKAY;
         if (s_axi_araddr == addr_of(`SP_IDX_CTRL)) begin
            s_axi_rdata <= {24'h00_0000, (fe_enable ? fe_r : ctrl_r.sm0), ctrl_r[6:0]};
         end else if (s_axi_araddr == addr_of(`SP_IDX_DATA)) begin
            s_axi_rdata <= {24'h00_0000, rx_buf_r};
         end else if (s_axi_araddr == addr_of(`SP_IDX_PWR)) begin
            s_axi_rdata <= {24'h00_0000, pwr_r};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SP_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Control and power registers; hardware sets win over software writes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `SP_CTRL_RST;
         fe_r <= 1'b0;
         pwr_r <= `SP_PWR_RST;
         ren_prev_r <= 1'b0;
      end else begin
         ren_prev_r <= ctrl_r.ren;
         if (wr_pwr) begin
            pwr_r <= wbyte_r & `SP_PWR_WMASK;
         end
         if (wr_ctrl) begin
            ctrl_r[6:0] <= wbyte_r[6:0];
            if (fe_enable) begin
               fe_r <= wbyte_r[7];
            end else begin
               ctrl_r.sm0 <= wbyte_r[7];
            end
         end
         if (ti_set) begin
            ctrl_r.ti <= 1'b1;
         end
         if (ri_set) begin
            ctrl_r.ri <= 1'b1;
            ctrl_r.rb8 <= rb8_val;
         end
         if (fe_set) begin
            fe_r <= 1'b1;
         end
      end
   end

   // Receive register, loaded only on an accepted byte
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_buf_r <= `SP_DATA_RST;
      end else if (ri_set) begin
         rx_buf_r <= rx_load;
      end
   end

   // 16x oversampling tick for the asynchronous modes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         presc_r <= 7'd0;
         t1_half_r <= 1'b0;
      end else begin
         if (ovs_tick || mode != 2'b10) begin
            presc_r <= 7'd0;
         end else begin
            presc_r <= presc_r + 7'd1;
         end
         if (t1_overflow) begin
            t1_half_r <= !t1_half_r;
         end
      end
   end

   always_comb begin
      if (mode == 2'b10) begin
         ovs_tick = (presc_r == (baud_double ? `SP_M2_DIV_FAST / `SP_OVS : `SP_M2_DIV_SLOW / `SP_OVS) - 7'd1);
      end else begin
         // Overflow over 32, or over 16 when doubled
         ovs_tick = t1_overflow && (baud_double || t1_half_r);
      end
   end

   // Mode 0 synchronous shifter
   m0_state_t m0_state_r;
   logic [3:0] m0_cnt_r, m0_bits_r, m0_half;
   logic m0_clk_r, m0_rx_start, m0_ti, m0_ri;
   logic [7:0] m0_sh_r;

   assign m0_half = ctrl_r.sm2 ? (`SP_M0_DIV_FAST >> 1) : (`SP_M0_DIV_SLOW >> 1);
   assign m0_rx_start = (mode == 2'b00) && ctrl_r.ren && !ren_prev_r && !ctrl_r.ri;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         m0_state_r <= M0_IDLE;
         m0_cnt_r <= 4'd0;
         m0_bits_r <= 4'd0;
         m0_clk_r <= 1'b1;
         m0_sh_r <= 8'h00;
         m0_ti <= 1'b0;
         m0_ri <= 1'b0;
      end else begin
         m0_ti <= 1'b0;
         m0_ri <= 1'b0;
         case (m0_state_r)
            M0_IDLE: begin
               m0_clk_r <= 1'b1;
               m0_cnt_r <= 4'd0;
               m0_bits_r <= 4'd0;
               if (wr_data && mode == 2'b00) begin
                  m0_sh_r <= wbyte_r;
                  m0_clk_r <= 1'b0;
                  m0_state_r <= M0_TX;
               end else if (m0_rx_start) begin
                  m0_clk_r <= 1'b0;
                  m0_state_r <= M0_RX;
               end
            end
            M0_TX, M0_RX: begin
               if (m0_cnt_r == m0_half - 4'd1) begin
                  m0_cnt_r <= 4'd0;
                  m0_clk_r <= !m0_clk_r;
                  if (!m0_clk_r && m0_state_r == M0_RX) begin
                     m0_sh_r <= {serial_data_in, m0_sh_r[7:1]};
                  end
                  if (m0_clk_r) begin
                     if (m0_state_r == M0_TX) begin
                        m0_sh_r <= {1'b0, m0_sh_r[7:1]};
                     end
                     m0_bits_r <= m0_bits_r + 4'd1;
                     if (m0_bits_r == 4'd7) begin
                        m0_clk_r <= 1'b1;
                        m0_state_r <= M0_IDLE;
                        m0_ti <= (m0_state_r == M0_TX);
                        m0_ri <= (m0_state_r == M0_RX);
                     end
                  end
               end else begin
                  m0_cnt_r <= m0_cnt_r + 4'd1;
               end
            end
            default: begin
               m0_state_r <= M0_IDLE;
            end
         endcase
      end
   end

   // Asynchronous transmitter
   tx_state_t tx_state_r;
   logic [10:0] tx_sh_r;
   logic [3:0] tx_bits_r, tx_tick_r;
   logic tx_ti, tx_wait_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_state_r <= TX_IDLE;
         tx_sh_r <= 11'h7ff;
         tx_bits_r <= 4'd0;
         tx_tick_r <= 4'd0;
         tx_ti <= 1'b0;
         tx_wait_r <= 1'b0;
      end else begin
         tx_ti <= 1'b0;
         case (tx_state_r)
            TX_IDLE: begin
               tx_sh_r <= 11'h7ff;
               if (wr_data && mode != 2'b00) begin
                  // Mode 1 puts stop where the ninth bit would be
                  tx_sh_r <= {1'b1, (mode == 2'b01) ? 1'b1 : ctrl_r.tb8, wbyte_r, 1'b0};
                  tx_bits_r <= 4'd0;
                  tx_tick_r <= 4'd0;
                  tx_wait_r <= 1'b1;
                  tx_state_r <= TX_BUSY;
               end
            end
            TX_BUSY: begin
               if (ovs_tick && tx_wait_r) begin
                  // Start bit begins on a tick so it lasts a full 16 ticks
                  tx_wait_r <= 1'b0;
               end else if (ovs_tick) begin
                  tx_tick_r <= tx_tick_r + 4'd1;
                  if (tx_tick_r == 4'd15) begin
                     tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                     tx_bits_r <= tx_bits_r + 4'd1;
                     // Flag rises as the stop bit goes on the line
                     if (tx_bits_r == ((mode == 2'b01) ? 4'd8 : 4'd9)) begin
                        tx_ti <= 1'b1;
                     end
                     if (tx_bits_r == ((mode == 2'b01) ? 4'd9 : 4'd10)) begin
                        tx_state_r <= TX_IDLE;
                     end
                  end
               end
            end
            default: begin
               tx_state_r <= TX_IDLE;
            end
         endcase
      end
   end

   // Asynchronous receiver
   rx_state_t rx_state_r;
   logic [8:0] rx_sh_r;
   logic [3:0] rx_bits_r, rx_tick_r;
   logic rxd_prev_r, rx_accept, rx_fe, rx_decide, rx_last;

   assign rx_decide = (rx_state_r == RX_BITS) && ovs_tick && (rx_tick_r == 4'd15) && (rx_bits_r == 4'd8);
   assign rx_last = (rx_state_r == RX_BITS) && ovs_tick && (rx_tick_r == 4'd15) &&
                    (rx_bits_r == ((mode == 2'b01) ? 4'd8 : 4'd9));

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_state_r <= RX_IDLE;
         rx_sh_r <= 9'h000;
         rx_bits_r <= 4'd0;
         rx_tick_r <= 4'd0;
         rxd_prev_r <= 1'b1;
         rx_accept <= 1'b0;
         rx_fe <= 1'b0;
      end else begin
         rxd_prev_r <= serial_data_in;
         rx_accept <= 1'b0;
         rx_fe <= 1'b0;
         case (rx_state_r)
            RX_IDLE: begin
               rx_tick_r <= 4'd0;
               rx_bits_r <= 4'd0;
               if (ctrl_r.ren && mode != 2'b00 && rxd_prev_r && !serial_data_in) begin
                  rx_state_r <= RX_START;
               end
            end
            RX_START: begin
               if (ovs_tick) begin
                  rx_tick_r <= rx_tick_r + 4'd1;
                  if (rx_tick_r == 4'd7) begin
                     rx_tick_r <= 4'd0;
                     // A glitch that is high again at mid start is dropped
                     rx_state_r <= serial_data_in ? RX_IDLE : RX_BITS;
                  end
               end
            end
            RX_BITS: begin
               if (ovs_tick) begin
                  rx_tick_r <= rx_tick_r + 4'd1;
                  if (rx_tick_r == 4'd15) begin
                     rx_sh_r <= {serial_data_in, rx_sh_r[8:1]};
                     rx_bits_r <= rx_bits_r + 4'd1;
                     if (rx_decide) begin
                        rx_accept <= !ctrl_r.ri && (!ctrl_r.sm2 || serial_data_in);
                     end
                     if (rx_last) begin
                        rx_fe <= !serial_data_in;
                        rx_state_r <= RX_IDLE;
                     end
                  end
               end
            end
            default: begin
               rx_state_r <= RX_IDLE;
            end
         endcase
      end
   end

   // After the decision shift rx_sh_r holds the data at [7:0] and the decision bit at [8]
   always_comb begin
      ti_set = m0_ti || tx_ti;
      ri_set = m0_ri || rx_accept;
      fe_set = rx_fe;
      if (m0_ri) begin
         rx_load = m0_sh_r;
         rb8_val = ctrl_r.rb8;
      end else begin
         rx_load = rx_sh_r[7:0];
         rb8_val = rx_sh_r[8];
      end
   end

   // Pin and status outputs, all registered
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_out_pin <= 1'b1;
         serial_data_out <= 1'b1;
         serial_data_oe <= 1'b0;
         serial_control <= `SP_CTRL_RST;
         serial_irq <= 1'b0;
      end else begin
         serial_out_pin <= (mode == 2'b00) ? m0_clk_r : (tx_wait_r ? 1'b1 : tx_sh_r[0]);
         serial_data_out <= (m0_state_r == M0_TX) ? m0_sh_r[0] : 1'b1;
         serial_data_oe <= (m0_state_r == M0_TX);
         serial_control <= ctrl_r;
         serial_irq <= ctrl_r.ti || ctrl_r.ri;
      end
   end
endmodule : serial_port
`default_nettype wire

// [verilog/serial_port_cfg.svh]
// Offsets, field positions, reset values and rate figures of the serial port
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH
// Register indices; the byte address is four times the index
`define SP_IDX_PWR 8'h87
`define SP_IDX_CTRL 8'h98
`define SP_IDX_DATA 8'h99
`define SP_PWR_DOUBLE 7
`define SP_PWR_FEEN 6
`define SP_PWR_WMASK 8'hdf
`define SP_PWR_RST 8'h00
`define SP_CTRL_RST 8'h00
`define SP_DATA_RST 8'h00
// Clock divisions
`define SP_M0_DIV_SLOW 4'd12
`define SP_M0_DIV_FAST 4'd4
`define SP_M2_DIV_SLOW 7'd64
`define SP_M2_DIV_FAST 7'd32
`define SP_OVS 7'd16
`define SP_RESP_OKAY 2'b00
`define SP_RESP_SLVERR 2'b10
`endif

// [verilog/serial_port_pkg.sv]
// Types of the serial port
package serial_port_pkg;
   typedef struct packed {
      logic sm0;
      logic sm1;
      logic sm2;
      logic ren;
      logic tb8;
      logic rb8;
      logic ti;
      logic ri;
   } ctrl_t;
   typedef enum logic [2:0] {
      M0_IDLE = 3'b001,
      M0_TX = 3'b010,
      M0_RX = 3'b100
   } m0_state_t;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_BUSY = 2'b10
   } tx_state_t;
   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_START = 3'b010,
      RX_BITS = 3'b100
   } rx_state_t;
endpackage : serial_port_pkg
